// ==== pis_edge.sv ====
// module: rising-edge pulse from a synchronised level
`timescale 1ns/1ps
module pis_edge (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      pulse
);
	logic levelQ;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			levelQ <= 1'b0;
		end else begin
			levelQ <= level;
		end
	end

	assign pulse = level & ~levelQ;
endmodule

// ==== pis_pkg.sv ====
// package: register map, field layout and bus carrier types for the status block
package pis_pkg;

	// =====================================================================
	// register map (byte addresses, one aligned word each)
	// =====================================================================
	localparam logic [7:0] PIS_ADDR_STATUS0 = 8'h00;
	localparam logic [7:0] PIS_ADDR_ENABLE  = 8'h04;
	localparam logic [7:0] PIS_ADDR_PORTCHG = 8'h08;

	// =====================================================================
	// field positions
	// =====================================================================
	localparam int PIS_BIT_EXT    = 0;
	localparam int PIS_BIT_CHANGE = 4;
	localparam int PIS_BIT_TIMER  = 5;
	localparam int PIS_BIT_GIE    = 7;

	// =====================================================================
	// reset values
	// =====================================================================
	localparam logic [7:0] PIS_RST_STATUS0 = 8'h00;
	localparam logic [7:0] PIS_RST_ENABLE  = 8'h00;
	localparam logic [7:0] PIS_RST_PORTCHG = 8'h00;

	// widths and cycle counts
	localparam int         PIS_ADDR_W    = 8;
	localparam int         PIS_PORT_W    = 8;
	localparam logic [1:0] PIS_RD_LATENCY = 2'h1;

	// =====================================================================
	// bus carrier types
	// =====================================================================
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} pis_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
		logic [1:0]  response;
	} pis_rsp_t;

	typedef enum logic [2:0] {
		PIS_IDLE = 3'b001,
		PIS_WAIT = 3'b010,
		PIS_DONE = 3'b100
	} pis_state_t;

endpackage

// ==== pis_status0.sv ====
// module: peripheral interrupt status register 0 with Avalon-MM slave
//
// Operation
// - timer-0 overflow sets bit 5, software clears
// - change summary bit 4 is read-only
// - external pin event sets bit 0, software clears
// - flags set regardless of enables
// - unimplemented bits and addresses read zero
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module pis_status0
	import pis_pkg::*;
#(
	parameter int PORT_W = PIS_PORT_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire pis_pkg::pis_req_t avReq,
	output pis_pkg::pis_rsp_t      avRsp,
	input  wire logic              timer0Overflow,
	input  wire logic              extPin,
	input  wire logic [PORT_W-1:0] portChangeEvent,
	output logic                   irqRequest
);
	import pis_pkg::*;

	// =====================================================================
	// state
	// =====================================================================
	pis_state_t        state;
	pis_state_t        next_state;
	logic              timer0OverflowFlag;
	logic              externalPinIrqFlag;
	logic [PORT_W-1:0] portChangeFlags;
	logic              changeSummaryFlag;
	logic              timerEnable;
	logic              changeEnable;
	logic              extEnable;
	logic              globalIrqEnable;
	logic [31:0]       readData;
	logic [1:0]        readResp;
	logic              extLevel;
	logic              extRise;
	logic [PORT_W-1:0] portEvtSync;
	logic              accept;
	logic              wrStatus;
	logic              wrEnable;
	logic              wrPortChg;
	logic              validAddr;
	logic [31:0]       next_readData;
	logic [7:0]        statusView;
	logic [7:0]        enableView;

	// =====================================================================
	// pin synchronisation and edge detection
	// =====================================================================
	pis_sync #(.WIDTH(1)) uExtSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   (extPin),
		.syncOut (extLevel)
	);

	pis_edge uExtEdge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (extLevel),
		.pulse (extRise)
	);

	pis_sync #(.WIDTH(PORT_W)) uPortSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   (portChangeEvent),
		.syncOut (portEvtSync)
	);

	// =====================================================================
	// bus decode
	// =====================================================================
	assign validAddr = (avReq.address == PIS_ADDR_STATUS0) |
	                   (avReq.address == PIS_ADDR_ENABLE)  |
	                   (avReq.address == PIS_ADDR_PORTCHG);
	assign accept    = (state == PIS_DONE);
	assign wrStatus  = accept & avReq.write & avReq.byteenable[0] &
	                   (avReq.address == PIS_ADDR_STATUS0);
	assign wrEnable  = accept & avReq.write & avReq.byteenable[0] &
	                   (avReq.address == PIS_ADDR_ENABLE);
	assign wrPortChg = accept & avReq.write & avReq.byteenable[0] &
	                   (avReq.address == PIS_ADDR_PORTCHG);

	// request held until waitrequest low; waitrequest high in IDLE and WAIT, two cycles, then low in DONE
	always_comb begin
		next_state = state;
		unique case (state)
			PIS_IDLE: begin
				if (avReq.read | avReq.write) begin
					next_state = PIS_WAIT;
				end
			end
			PIS_WAIT: begin
				next_state = PIS_DONE;
			end
			PIS_DONE: begin
				next_state = PIS_IDLE;
			end
			default: begin
				next_state = PIS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PIS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// =====================================================================
	// flags: set wins over software clear
	// =====================================================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer0OverflowFlag <= PIS_RST_STATUS0[PIS_BIT_TIMER];
		end else if (timer0Overflow) begin
			timer0OverflowFlag <= 1'b1;
		end else if (wrStatus) begin
			timer0OverflowFlag <= timer0OverflowFlag & avReq.writedata[PIS_BIT_TIMER];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			externalPinIrqFlag <= PIS_RST_STATUS0[PIS_BIT_EXT];
		end else if (extRise) begin
			externalPinIrqFlag <= 1'b1;
		end else if (wrStatus) begin
			externalPinIrqFlag <= externalPinIrqFlag & avReq.writedata[PIS_BIT_EXT];
		end
	end

	// port change flags: write zero to clear, event sets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portChangeFlags <= PIS_RST_PORTCHG[PORT_W-1:0];
		end else if (wrPortChg) begin
			portChangeFlags <= (portChangeFlags & avReq.writedata[PORT_W-1:0]) | portEvtSync;
		end else begin
			portChangeFlags <= portChangeFlags | portEvtSync;
		end
	end

	assign changeSummaryFlag = |portChangeFlags;

	// =====================================================================
	// enables
	// =====================================================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timerEnable     <= PIS_RST_ENABLE[PIS_BIT_TIMER];
			changeEnable    <= PIS_RST_ENABLE[PIS_BIT_CHANGE];
			extEnable       <= PIS_RST_ENABLE[PIS_BIT_EXT];
			globalIrqEnable <= PIS_RST_ENABLE[PIS_BIT_GIE];
		end else if (wrEnable) begin
			timerEnable     <= avReq.writedata[PIS_BIT_TIMER];
			changeEnable    <= avReq.writedata[PIS_BIT_CHANGE];
			extEnable       <= avReq.writedata[PIS_BIT_EXT];
			globalIrqEnable <= avReq.writedata[PIS_BIT_GIE];
		end
	end

	// enables only gate the request, never the flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= globalIrqEnable & ((timer0OverflowFlag & timerEnable) |
			              (changeSummaryFlag & changeEnable) |
			              (externalPinIrqFlag & extEnable));
		end
	end

	// =====================================================================
	// read path
	// =====================================================================
	always_comb begin
		statusView = 8'h00;
		statusView[PIS_BIT_TIMER]  = timer0OverflowFlag;
		statusView[PIS_BIT_CHANGE] = changeSummaryFlag;
		statusView[PIS_BIT_EXT]    = externalPinIrqFlag;
		enableView = 8'h00;
		enableView[PIS_BIT_TIMER]  = timerEnable;
		enableView[PIS_BIT_CHANGE] = changeEnable;
		enableView[PIS_BIT_EXT]    = extEnable;
		enableView[PIS_BIT_GIE]    = globalIrqEnable;
		next_readData = 32'h0000_0000;
		if (avReq.address == PIS_ADDR_STATUS0) begin
			next_readData = {24'h00_0000, statusView};
		end else if (avReq.address == PIS_ADDR_ENABLE) begin
			next_readData = {24'h00_0000, enableView};
		end else if (avReq.address == PIS_ADDR_PORTCHG) begin
			next_readData = {{(32-PORT_W){1'b0}}, portChangeFlags};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readData <= 32'h0000_0000;
			readResp <= 2'h0;
		end else if (state == PIS_WAIT) begin
			readData <= avReq.read ? next_readData : 32'h0000_0000;
			readResp <= validAddr ? 2'h0 : 2'h2;
		end else if (state == PIS_DONE) begin
			readData <= 32'h0000_0000;
			readResp <= 2'h0;
		end
	end

	// one driver for the whole response carrier
	assign avRsp = '{waitrequest: (avReq.read | avReq.write) & ~accept,
	                 readdata:    readData,
	                 response:    readResp};

	// =====================================================================
	// assertions
	// =====================================================================
	property p_timerSet;
		@(posedge clk) disable iff (!rst_n)
		timer0Overflow |=> timer0OverflowFlag;
	endproperty
	a_timerSet: assert property (p_timerSet) else $error("timer flag not set");

	property p_extSet;
		@(posedge clk) disable iff (!rst_n)
		$rose(extPin) ##3 1'b1 |-> externalPinIrqFlag;
	endproperty
	a_extSet: assert property (p_extSet) else $error("external flag not set");

	property p_summary;
		@(posedge clk) disable iff (!rst_n)
		changeSummaryFlag == (portChangeFlags != '0);
	endproperty
	a_summary: assert property (p_summary) else $error("summary mismatch");

	property p_readOnly;
		@(posedge clk) disable iff (!rst_n)
		wrStatus && portEvtSync == '0 |=> $stable(changeSummaryFlag);
	endproperty
	a_readOnly: assert property (p_readOnly) else $error("summary changed by write");

	property p_noEnableNeeded;
		@(posedge clk) disable iff (!rst_n)
		timer0Overflow && !globalIrqEnable |=> timer0OverflowFlag;
	endproperty
	a_noEnableNeeded: assert property (p_noEnableNeeded) else $error("flag gated");

	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		accept && avReq.read && !validAddr |-> avRsp.readdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

	property p_upperZero;
		@(posedge clk) disable iff (!rst_n)
		accept && avReq.read && avReq.address == PIS_ADDR_STATUS0
		|-> avRsp.readdata[31:6] == '0 && avRsp.readdata[3:1] == '0;
	endproperty
	a_upperZero: assert property (p_upperZero) else $error("reserved bit set");

	property p_clearWorks;
		@(posedge clk) disable iff (!rst_n)
		wrStatus && !avReq.writedata[PIS_BIT_TIMER] && !timer0Overflow
		|=> !timer0OverflowFlag;
	endproperty
	a_clearWorks: assert property (p_clearWorks) else $error("clear failed");

	property p_answer;
		@(posedge clk) disable iff (!rst_n)
		state == PIS_IDLE && (avReq.read | avReq.write) |-> ##2 !avRsp.waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("answer late");

	property p_extClear;
		@(posedge clk) disable iff (!rst_n)
		wrStatus && !avReq.writedata[PIS_BIT_EXT] && !extRise |=> !externalPinIrqFlag;
	endproperty
	a_extClear: assert property (p_extClear) else $error("external clear failed");

	property p_changeSets;
		@(posedge clk) disable iff (!rst_n)
		portEvtSync != '0 |=> changeSummaryFlag;
	endproperty
	a_changeSets: assert property (p_changeSets) else $error("summary not set");

	property p_extNoEnable;
		@(posedge clk) disable iff (!rst_n)
		extRise && !extEnable |=> externalPinIrqFlag;
	endproperty
	a_extNoEnable: assert property (p_extNoEnable) else $error("external flag gated");

	property p_resetClear;
		@(posedge clk)
		$rose(rst_n) |-> !timer0OverflowFlag && !externalPinIrqFlag && portChangeFlags == '0;
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("flags not cleared");
endmodule

// ==== pis_status0_tb.sv ====
// testbench: register access, flag set and clear, and reset checks for the status block
`timescale 1ns/1ps
module testbench;
	import pis_pkg::*;

	// ==========================================================
	// signals and design
	// ==========================================================
	localparam logic [31:0] TF = 32'h1 << PIS_BIT_TIMER;
	localparam logic [31:0] CF = 32'h1 << PIS_BIT_CHANGE;
	localparam logic [31:0] EF = 32'h1 << PIS_BIT_EXT;
	logic        clk;
	logic        rst_n;
	pis_req_t    avReq;
	pis_rsp_t    avRsp;
	logic        timer0Overflow;
	logic        extPin;
	logic [7:0]  portChangeEvent;
	logic        irqRequest;
	logic [31:0] rdData;
	logic [1:0]  rdResp;
	int          bad_count;
	int          samples_checked;

	always #25 clk = ~clk;

	pis_status0 #(.PORT_W(8)) u_pis_status0 (
		.clk            (clk),
		.rst_n          (rst_n),
		.avReq          (avReq),
		.avRsp          (avRsp),
		.timer0Overflow (timer0Overflow),
		.extPin         (extPin),
		.portChangeEvent(portChangeEvent),
		.irqRequest     (irqRequest)
	);

	// ==========================================================
	// shared tasks
	// ==========================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	task automatic tally_and_finish;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// request held until waitrequest seen low, released after that edge
	task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
			input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avReq <= {rd, ~rd, a, {24'h000000, d}, be};
		@(posedge clk);
		// sampled at the rising edge; write lands and read data is taken there
		while (avRsp.waitrequest !== 1'b0) begin
			n++;
			if (n > 50) begin
				bad_count++;
				tally_and_finish();
			end
			@(posedge clk);
		end
		rdData = avRsp.readdata;
		rdResp = avRsp.response;
		avReq <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b0, a, d, 4'h1);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		bus(1'b1, a, 8'h00, 4'hF);
		check(rdData, e);
		check({30'h0, rdResp}, {30'h0, r});
	endtask

	task automatic pulse_timer;
		@(posedge clk);
		timer0Overflow <= 1'b1;
		@(posedge clk);
		timer0Overflow <= 1'b0;
	endtask

	task automatic port_event(input logic [7:0] v);
		@(posedge clk);
		portChangeEvent <= v;
		repeat (6) @(posedge clk);
		portChangeEvent <= 8'h00;
		repeat (4) @(posedge clk);
	endtask

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_reset_values;
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
		rdchk(PIS_ADDR_ENABLE, 32'h0, 2'h0);
		rdchk(PIS_ADDR_PORTCHG, 32'h0, 2'h0);
	endtask

	task automatic t_timer;
		pulse_timer();
		rdchk(PIS_ADDR_STATUS0, TF, 2'h0);
		wr(PIS_ADDR_STATUS0, 8'hFF);
		rdchk(PIS_ADDR_STATUS0, TF, 2'h0);
		wr(PIS_ADDR_STATUS0, 8'h00);
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
	endtask

	task automatic t_ext;
		@(posedge clk);
		extPin <= 1'b1;
		repeat (6) @(posedge clk);
		extPin <= 1'b0;
		repeat (6) @(posedge clk);
		rdchk(PIS_ADDR_STATUS0, EF, 2'h0);
		wr(PIS_ADDR_STATUS0, 8'hFE);
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
	endtask

	task automatic t_change;
		port_event(8'h81);
		rdchk(PIS_ADDR_PORTCHG, 32'h81, 2'h0);
		wr(PIS_ADDR_STATUS0, 8'h00);
		rdchk(PIS_ADDR_STATUS0, CF, 2'h0);
		wr(PIS_ADDR_PORTCHG, 8'hFE);
		rdchk(PIS_ADDR_STATUS0, CF, 2'h0);
		wr(PIS_ADDR_PORTCHG, 8'h7F);
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
		wr(PIS_ADDR_STATUS0, 8'hFF);
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
	endtask

	task automatic t_unmapped;
		rdchk(8'h0C, 32'h0, 2'h2);
		wr(8'h10, 8'hFF);
		rdchk(PIS_ADDR_ENABLE, 32'h0, 2'h0);
		rdchk(PIS_ADDR_PORTCHG, 32'h0, 2'h0);
		pulse_timer();
		bus(1'b0, PIS_ADDR_STATUS0, 8'h00, 4'h0);
		rdchk(PIS_ADDR_STATUS0, TF, 2'h0);
	endtask

	task automatic t_irq;
		wr(PIS_ADDR_STATUS0, 8'h00);
		wr(PIS_ADDR_ENABLE, 8'h20);
		rdchk(PIS_ADDR_ENABLE, 32'h20, 2'h0);
		pulse_timer();
		rdchk(PIS_ADDR_STATUS0, TF, 2'h0);
		check({31'h0, irqRequest}, 32'h0);
		wr(PIS_ADDR_ENABLE, 8'hA0);
		repeat (2) @(negedge clk);
		check({31'h0, irqRequest}, 32'h1);
		wr(PIS_ADDR_STATUS0, 8'h00);
		repeat (2) @(negedge clk);
		check({31'h0, irqRequest}, 32'h0);
	endtask

	// change and pin sources raise the request with their enables and the global enable set
	task automatic t_sources;
		wr(PIS_ADDR_PORTCHG, 8'h00);
		wr(PIS_ADDR_STATUS0, 8'h00);
		wr(PIS_ADDR_ENABLE, 8'h91);
		repeat (2) @(negedge clk);
		check({31'h0, irqRequest}, 32'h0);
		port_event(8'h04);
		check({31'h0, irqRequest}, 32'h1);
		wr(PIS_ADDR_PORTCHG, 8'hFB);
		repeat (2) @(negedge clk);
		check({31'h0, irqRequest}, 32'h0);
		@(posedge clk);
		extPin <= 1'b1;
		repeat (6) @(posedge clk);
		extPin <= 1'b0;
		check({31'h0, irqRequest}, 32'h1);
		wr(PIS_ADDR_STATUS0, 8'h00);
		repeat (2) @(negedge clk);
		check({31'h0, irqRequest}, 32'h0);
	endtask

	task automatic t_midreset;
		port_event(8'h10);
		pulse_timer();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(PIS_ADDR_STATUS0, 32'h0, 2'h0);
		rdchk(PIS_ADDR_ENABLE, 32'h0, 2'h0);
		rdchk(PIS_ADDR_PORTCHG, 32'h0, 2'h0);
		check({31'h0, irqRequest}, 32'h0);
	endtask

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		avReq = '0;
		timer0Overflow = 1'b0;
		extPin = 1'b0;
		portChangeEvent = 8'h00;
		bad_count = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_values();
		t_timer();
		t_ext();
		t_change();
		t_unmapped();
		t_irq();
		t_sources();
		t_midreset();
		tally_and_finish();
	end
endmodule

// ==== pis_sync.sv ====
// module: two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pis_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= '0;
			syncOut <= '0;
		end else begin
			stage1  <= pinIn;
			syncOut <= stage1;
		end
	end
endmodule
